// ### rtl/ckg_pkg.sv
// Constants and types of the main clock select and oscillator
// stabilization block.
// Assumes a byte-addressed register port, one 32-bit word per register.
// What this block does
// R1: Select bit picks main clock; 0 on-chip oscillator, 1 high-speed system.
// R2: Source status bit 5 is read-only; writes do not change it.
// R3: Software never selects high-speed while frequency option or PLL bit set.
// R4: Software writes 0 to bits 7, 6 and 3 of the clock control register.
// R5: Run control resets to c0; high-speed stopped, on-chip oscillator runs.
// R6: Bit 7 stops crystal, ignores external input, or does nothing.
// R7: Bit 0 of run control stops the on-chip oscillator when 1.
// R8: Software programs pin mode register before the run control register.
// R9: Software sets wait select before clearing the high-speed stop bit.
// R10: Software never stops the oscillator currently feeding the CPU.
// R11: Progress status clears on reset, STOP entry, and stop bit set.
// R12: Counting starts on crystal start or on STOP release.
// R13: Progress bits set from MSB down at 2^8..2^18 crystal counts, sticky.
// R14: Progress status is read-only, readable as bit or byte.
// R15: Wait select codes give 2^8..2^11, 2^13, 2^15, 2^17, 2^18 cycles; upper bits zero.
// R16: Wait select resets to 07, the longest wait.
// R17: Crystal clock is held off until the selected wait has elapsed.
// R18: Counter stops at the selected wait; status shows only up to it.
// R19: Software picks a wait longer than the count it will check.
// R20: Only crystal edges are counted; start-up delay is not included.
// R21: Software polls progress status before switching to the crystal.
// R22: Wait select is written as a whole byte only.
// R23: Select at bit 4, status at bit 5; clock control resets to 00.
// R24: Binary crystal counter; each status bit is a sticky threshold.

`default_nettype none

package ckg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [19:0] PIN_MODE_IDX = 20'hfffa0;
  localparam logic [19:0] OSC_RUN_IDX = 20'hfffa1;
  localparam logic [19:0] STAB_STAT_IDX = 20'hfffa2;
  localparam logic [19:0] WAIT_SEL_IDX = 20'hfffa3;
  localparam logic [19:0] SYS_CTRL_IDX = 20'hfffa4;
  localparam int ADDR_W = 22;

  // Field positions
  localparam int PIN_EXT_BIT = 7;
  localparam int PIN_XTAL_BIT = 6;
  localparam int PIN_AMP_BIT = 0;
  localparam int HS_STOP_BIT = 7;
  localparam int RUN_ONE_BIT = 6;
  localparam int ONCHIP_STOP_BIT = 0;
  localparam int MAIN_STATUS_BIT = 5;
  localparam int MAIN_SELECT_BIT = 4;

  // Reset values
  localparam logic [7:0] PIN_MODE_RST = 8'h00;
  localparam logic [7:0] OSC_RUN_RST = 8'hc0;
  localparam logic [7:0] STAB_STAT_RST = 8'h00;
  localparam logic [2:0] WAIT_SEL_RST = 3'h7;
  localparam logic [7:0] SYS_CTRL_RST = 8'h00;

  // Crystal counter reaches 2^18
  localparam int CNT_W = 19;

  typedef enum logic [1:0] {
    STAB_IDLE = 2'b00,
    STAB_COUNT = 2'b01,
    STAB_DONE = 2'b10
  } ckg_stab_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } ckg_req_type;

  typedef struct packed {
    logic onchip_run;
    logic xtal_run;
    logic ext_accept;
    logic hs_ready;
    logic main_status;
  } ckg_clk_type;

endpackage

`default_nettype wire

// ### rtl/ckg_main_clock.sv
// Main clock source select, oscillator run control and crystal
// stabilization counter, with a small register port.
// Assumes crystal_clock is an asynchronous pin far slower than clock,
// and STOP entry and release arrive as one-cycle pulses on clock.
//
// Added by the designer: the address-and-strobe port.

`default_nettype none

module ckg_main_clock (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire ckg_pkg::ckg_req_type req,
  output logic [31:0] rd_data,
  // Power mode events
  input wire logic stop_enter,
  input wire logic stop_release,
  // Option byte and PLL select levels
  input wire logic osc_freq_option_bit,
  input wire logic pll_source_select,
  // Crystal clock pin
  input wire logic crystal_clock,
  // Clock controls and status
  output ckg_pkg::ckg_clk_type clk_ctrl
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0] pin_mode;
    logic pin_mode_locked;
    logic hs_stop;
    logic onchip_stop;
    logic main_select;
    logic main_status;
    logic [2:0] wait_sel;
    logic [ckg_pkg::CNT_W-1:0] count;
    logic [7:0] progress;
    ckg_pkg::ckg_stab_type stab;
    logic in_stop;
    logic xtal_s1;
    logic xtal_s2;
    logic xtal_s3;
    logic [31:0] rd_data;
    ckg_pkg::ckg_clk_type clk;
  } ckg_state_type;

  ckg_state_type st;
  ckg_state_type next_st;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Exponent of the wait length for a select code
  function automatic logic [4:0] wait_exp(input logic [2:0] code);
    logic [4:0] e;
    e = 5'd8;
    case (code)
      3'h0: e = 5'd8;
      3'h1: e = 5'd9;
      3'h2: e = 5'd10;
      3'h3: e = 5'd11;
      3'h4: e = 5'd13;
      3'h5: e = 5'd15;
      3'h6: e = 5'd17;
      3'h7: e = 5'd18;
      default: e = 5'd18;
    endcase
    return e;
  endfunction

  function automatic logic [ckg_pkg::CNT_W-1:0] wait_len(
    input logic [2:0] code);
    logic [ckg_pkg::CNT_W-1:0] one;
    one = {{(ckg_pkg::CNT_W-1){1'b0}}, 1'b1};
    return one << wait_exp(code);
  endfunction

  // Thermometer from the counter, MSB set first
  function automatic logic [7:0] therm(
    input logic [ckg_pkg::CNT_W-1:0] cnt);
    logic [7:0] t;
    t = 8'h00;
    for (int i = 0; i < 8; i++) begin
      t[7-i] = (cnt >= wait_len(3'(i)));
    end
    return t;
  endfunction

  function automatic logic addr_hit(input logic [ckg_pkg::ADDR_W-1:0] a,
                                    input logic [19:0] idx);
    return a == {idx, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Decoded views

  logic xtal_mode;
  logic ext_mode;
  logic xtal_edge;
  logic [ckg_pkg::CNT_W-1:0] limit;
  logic [7:0] run_rd;
  logic [7:0] sys_rd;
  logic [7:0] wait_rd;

  always_comb begin
    xtal_mode = !st.pin_mode[ckg_pkg::PIN_EXT_BIT]
                && st.pin_mode[ckg_pkg::PIN_XTAL_BIT];
    ext_mode = st.pin_mode[ckg_pkg::PIN_EXT_BIT]
               && st.pin_mode[ckg_pkg::PIN_XTAL_BIT];
    // Only real crystal edges advance the count [R20]
    xtal_edge = st.xtal_s2 && !st.xtal_s3;
    limit = wait_len(st.wait_sel);
    run_rd = 8'h00;
    run_rd[ckg_pkg::HS_STOP_BIT] = st.hs_stop;
    run_rd[ckg_pkg::RUN_ONE_BIT] = 1'b1;
    run_rd[ckg_pkg::ONCHIP_STOP_BIT] = st.onchip_stop;
    sys_rd = 8'h00;
    sys_rd[ckg_pkg::MAIN_STATUS_BIT] = st.main_status;
    sys_rd[ckg_pkg::MAIN_SELECT_BIT] = st.main_select;
    // Upper five bits read zero [R15]
    wait_rd = {5'h00, st.wait_sel};
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  logic wr_run;
  logic wr_pin;
  logic wr_sys;
  logic wr_wait;
  logic start_xtal;

  always_comb begin
    next_st = st;
    wr_pin = req.wr && addr_hit(req.addr, ckg_pkg::PIN_MODE_IDX);
    wr_run = req.wr && addr_hit(req.addr, ckg_pkg::OSC_RUN_IDX);
    wr_wait = req.wr && addr_hit(req.addr, ckg_pkg::WAIT_SEL_IDX);
    wr_sys = req.wr && addr_hit(req.addr, ckg_pkg::SYS_CTRL_IDX);
    start_xtal = 1'b0;

    // Synchroniser for the crystal pin
    next_st.xtal_s1 = crystal_clock;
    next_st.xtal_s2 = st.xtal_s1;
    next_st.xtal_s3 = st.xtal_s2;

    // Pin mode register takes one write after reset
    if (wr_pin && !st.pin_mode_locked) begin
      next_st.pin_mode = 8'h00;
      next_st.pin_mode[ckg_pkg::PIN_EXT_BIT] =
        req.wdata[ckg_pkg::PIN_EXT_BIT];
      next_st.pin_mode[ckg_pkg::PIN_XTAL_BIT] =
        req.wdata[ckg_pkg::PIN_XTAL_BIT];
      next_st.pin_mode[ckg_pkg::PIN_AMP_BIT] =
        req.wdata[ckg_pkg::PIN_AMP_BIT];
      next_st.pin_mode_locked = 1'b1;
    end

    // Run control: only the two stop bits store [R6] [R7]
    if (wr_run) begin
      next_st.hs_stop = req.wdata[ckg_pkg::HS_STOP_BIT];
      next_st.onchip_stop = req.wdata[ckg_pkg::ONCHIP_STOP_BIT];
      // Crystal start on stop bit falling in crystal mode [R12]
      start_xtal = st.hs_stop && !req.wdata[ckg_pkg::HS_STOP_BIT]
                   && xtal_mode;
    end

    if (wr_wait) begin
      next_st.wait_sel = req.wdata[2:0];
    end

    // Only the select bit stores; status bit ignores writes [R2] [R23]
    if (wr_sys) begin
      next_st.main_select = req.wdata[ckg_pkg::MAIN_SELECT_BIT];
    end

    // Stabilization counter [R24]
    case (st.stab)
      ckg_pkg::STAB_IDLE: begin
        next_st.count = '0;
      end
      ckg_pkg::STAB_COUNT: begin
        // Halts at the selected length [R18]
        if (st.count >= limit) begin
          next_st.stab = ckg_pkg::STAB_DONE;
        end else if (xtal_edge) begin
          next_st.count = st.count + 1'b1;
        end
      end
      ckg_pkg::STAB_DONE: begin
        if (st.count < limit && !st.in_stop) begin
          next_st.stab = ckg_pkg::STAB_COUNT;
        end
      end
      default: begin
        next_st.stab = ckg_pkg::STAB_IDLE;
      end
    endcase

    // Sticky thermometer bits [R13]
    if (st.stab != ckg_pkg::STAB_IDLE) begin
      next_st.progress = st.progress | therm(st.count);
    end

    // STOP release restarts the count with the crystal enabled [R12]
    if (stop_release && st.in_stop) begin
      next_st.in_stop = 1'b0;
      if (xtal_mode && !st.hs_stop) begin
        start_xtal = 1'b1;
      end
    end

    if (start_xtal) begin
      next_st.stab = ckg_pkg::STAB_COUNT;
      next_st.count = '0;
      next_st.progress = 8'h00;
    end

    // Clearing events win over counting [R11]
    if (stop_enter || (wr_run && req.wdata[ckg_pkg::HS_STOP_BIT])) begin
      next_st.stab = ckg_pkg::STAB_IDLE;
      next_st.count = '0;
      next_st.progress = 8'h00;
    end
    if (stop_enter) begin
      next_st.in_stop = 1'b1;
    end

    // Oscillator enables [R6] [R7]
    next_st.clk.onchip_run = !next_st.onchip_stop && !next_st.in_stop;
    next_st.clk.xtal_run = xtal_mode && !next_st.hs_stop
                           && !next_st.in_stop;
    next_st.clk.ext_accept = ext_mode && !next_st.hs_stop
                             && !next_st.in_stop;
    // Crystal usable only after the wait [R17]
    next_st.clk.hs_ready = (xtal_mode && next_st.stab == ckg_pkg::STAB_DONE
                            && next_st.clk.xtal_run)
                           || next_st.clk.ext_accept;

    // Source follows select once the target clock is usable [R1]
    if (st.main_select && st.clk.hs_ready) begin
      next_st.main_status = 1'b1;
    end else if (!st.main_select && st.clk.onchip_run) begin
      next_st.main_status = 1'b0;
    end
    next_st.clk.main_status = next_st.main_status;

    // Read data stands one cycle after the strobe [R14]
    next_st.rd_data = 32'h0000_0000;
    if (req.rd) begin
      if (addr_hit(req.addr, ckg_pkg::PIN_MODE_IDX)) begin
        next_st.rd_data = {24'h000000, st.pin_mode};
      end else if (addr_hit(req.addr, ckg_pkg::OSC_RUN_IDX)) begin
        next_st.rd_data = {24'h000000, run_rd};
      end else if (addr_hit(req.addr, ckg_pkg::STAB_STAT_IDX)) begin
        next_st.rd_data = {24'h000000, st.progress};
      end else if (addr_hit(req.addr, ckg_pkg::WAIT_SEL_IDX)) begin
        next_st.rd_data = {24'h000000, wait_rd};
      end else if (addr_hit(req.addr, ckg_pkg::SYS_CTRL_IDX)) begin
        next_st.rd_data = {24'h000000, sys_rd};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.pin_mode <= ckg_pkg::PIN_MODE_RST;
      st.pin_mode_locked <= 1'b0;
      // Stopped crystal, running on-chip oscillator [R5]
      st.hs_stop <= ckg_pkg::OSC_RUN_RST[ckg_pkg::HS_STOP_BIT];
      st.onchip_stop <= ckg_pkg::OSC_RUN_RST[ckg_pkg::ONCHIP_STOP_BIT];
      st.main_select <= ckg_pkg::SYS_CTRL_RST[ckg_pkg::MAIN_SELECT_BIT];
      st.main_status <= ckg_pkg::SYS_CTRL_RST[ckg_pkg::MAIN_STATUS_BIT];
      st.wait_sel <= ckg_pkg::WAIT_SEL_RST; // [R16]
      st.count <= '0;
      st.progress <= ckg_pkg::STAB_STAT_RST; // [R11]
      st.stab <= ckg_pkg::STAB_IDLE;
      st.in_stop <= 1'b0;
      st.xtal_s1 <= 1'b0;
      st.xtal_s2 <= 1'b0;
      st.xtal_s3 <= 1'b0;
      st.rd_data <= 32'h0000_0000;
      st.clk.onchip_run <= 1'b1;
      st.clk.xtal_run <= 1'b0;
      st.clk.ext_accept <= 1'b0;
      st.clk.hs_ready <= 1'b0;
      st.clk.main_status <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data = st.rd_data;
  assign clk_ctrl = st.clk;

endmodule

`default_nettype wire

// ### test/ckg_main_clock_props.sv
// Port checker for the main clock select and stabilization block.
// Assumes one clock domain, rst_n asynchronous and active low.
`default_nettype none
module ckg_main_clock_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port and power events
  input wire ckg_pkg::ckg_req_type req,
  input wire logic [31:0] rd_data,
  input wire logic stop_enter,
  // Clock controls
  input wire ckg_pkg::ckg_clk_type clk_ctrl
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence rd_of(idx);
    req.rd && req.addr == {idx, 2'b00};
  endsequence
  sequence wr_run;
    req.wr && req.addr == {ckg_pkg::OSC_RUN_IDX, 2'b00} && !stop_enter;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  rd_idle_a: assert property (!req.rd |=> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  run_fixed_a: assert property (rd_of(ckg_pkg::OSC_RUN_IDX) |=>
    rd_data[31:8] == 24'h0 && rd_data[6] == 1'b1 && rd_data[5:1] == 5'h0)
    else $error("run control fixed bits wrong");
  ctrl_status_a: assert property (rd_of(ckg_pkg::SYS_CTRL_IDX) |=>
    rd_data[5] == $past(clk_ctrl.main_status) && rd_data[31:6] == 26'h0
    && rd_data[3:0] == 4'h0) else $error("clock control read wrong");
  wait_upper_a: assert property (rd_of(ckg_pkg::WAIT_SEL_IDX) |=>
    rd_data[31:3] == 29'h0) else $error("wait select upper bits set");
  hs_stop_a: assert property (wr_run ##0 req.wdata[7] |=>
    !clk_ctrl.xtal_run && !clk_ctrl.ext_accept)
    else $error("high-speed clock not stopped");
  onchip_ctl_a: assert property (wr_run |=>
    clk_ctrl.onchip_run == !$past(req.wdata[0]))
    else $error("on-chip oscillator enable wrong");
  src_rise_a: assert property ($rose(clk_ctrl.main_status) |->
    $past(clk_ctrl.hs_ready)) else $error("switched to unready clock");
  src_fall_a: assert property ($fell(clk_ctrl.main_status) |->
    $past(clk_ctrl.onchip_run)) else $error("switched to stopped clock");
  stop_clear_a: assert property (stop_enter |=>
    !clk_ctrl.onchip_run && !clk_ctrl.xtal_run)
    else $error("oscillators running after stop");
  stop_prog_a: assert property (stop_enter ##1
    rd_of(ckg_pkg::STAB_STAT_IDX) |=> rd_data == 32'h0)
    else $error("progress not cleared by stop");
endmodule
bind ckg_main_clock ckg_main_clock_props ckg_main_clock_props_i (
  .clock(clock), .rst_n(rst_n), .req(req), .rd_data(rd_data),
  .stop_enter(stop_enter), .clk_ctrl(clk_ctrl));
`default_nettype wire

// ### test/ckg_main_clock_tb_top.sv
// Self-checking bench: register port, crystal counting, STOP events.
// Assumes the checker is bound to the block and one 250 MHz clock.
`default_nettype none
module ckg_main_clock_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] RUN = ckg_pkg::OSC_RUN_IDX;
  localparam logic [19:0] STAT = ckg_pkg::STAB_STAT_IDX;
  localparam logic [19:0] WSEL = ckg_pkg::WAIT_SEL_IDX;
  localparam logic [19:0] SYS = ckg_pkg::SYS_CTRL_IDX;
  logic clock;
  logic rst_n;
  ckg_pkg::ckg_req_type req;
  logic [31:0] rd_data;
  logic stop_enter;
  logic stop_release;
  logic crystal_clock;
  ckg_pkg::ckg_clk_type clk_ctrl;
  int num_errors;
  int compares;
  logic [31:0] seed;
  logic [31:0] notes[$];
  logic rd_pend;
  ckg_main_clock ckg_main_clock_i (.clock(clock), .rst_n(rst_n),
    .req(req), .rd_data(rd_data), .stop_enter(stop_enter),
    .stop_release(stop_release), .osc_freq_option_bit(1'b0),
    .pll_source_select(1'b0), .crystal_clock(crystal_clock),
    .clk_ctrl(clk_ctrl));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One register access; strobe held until the caller goes idle
  task automatic acc(input logic w, input logic [19:0] idx,
                     input logic [7:0] d, input logic [31:0] exp);
    req <= '{wr: w, rd: !w, addr: {idx, 2'b00}, wdata: {24'h0, d}};
    if (!w) notes.push_back(exp);
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clock);
  endtask
  task automatic xtal(input int n);
    req <= '0;
    repeat (n) begin
      crystal_clock <= 1'b1;
      repeat (4) @(posedge clock);
      crystal_clock <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  task automatic pulse(input logic rel);
    req <= '0;
    stop_release <= rel;
    stop_enter <= !rel;
    @(posedge clock);
    stop_release <= 1'b0;
    stop_enter <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Read results checked against the oldest note
  always @(posedge clock) begin
    rd_pend <= req.rd;
    if (rd_pend === 1'b1) chk(rd_data, notes.pop_front(), "rd_data");
  end
  initial begin
    #160000;
    num_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    stop_enter = 1'b0;
    stop_release = 1'b0;
    crystal_clock = 1'b0;
    seed = 32'hf32d;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk({27'h0, clk_ctrl}, 32'h10, "clk_ctrl");
    acc(1'b0, RUN, 8'h0, 32'hc0);
    acc(1'b0, STAT, 8'h0, 32'h00);
    acc(1'b0, WSEL, 8'h0, 32'h07);
    acc(1'b0, SYS, 8'h0, 32'h00);
    acc(1'b0, 20'hfffa8, 8'h0, 32'h00);
    acc(1'b1, STAT, 8'hff, 32'h0);
    // Only the status bit written as 1; option and PLL tied low
    acc(1'b1, SYS, 8'h20, 32'h0);
    acc(1'b0, STAT, 8'h0, 32'h00);
    acc(1'b0, SYS, 8'h0, 32'h00);
    acc(1'b1, ckg_pkg::PIN_MODE_IDX, 8'h40, 32'h0);
    acc(1'b1, WSEL, 8'h00, 32'h0);
    acc(1'b1, RUN, 8'h00, 32'h0);
    acc(1'b0, RUN, 8'h0, 32'h40);
    idle(2);
    chk({27'h0, clk_ctrl}, 32'h18, "clk_ctrl");
    xtal(255);
    idle(4);
    acc(1'b0, STAT, 8'h0, 32'h00);
    idle(1);
    chk({27'h0, clk_ctrl}, 32'h18, "clk_ctrl");
    xtal(1);
    idle(4);
    acc(1'b0, STAT, 8'h0, 32'h80);
    idle(1);
    chk({27'h0, clk_ctrl}, 32'h1a, "clk_ctrl");
    xtal(300);
    idle(4);
    acc(1'b0, STAT, 8'h0, 32'h80);
    // Switch only after polling reached the wanted count
    acc(1'b1, SYS, 8'h10, 32'h0);
    idle(2);
    chk({27'h0, clk_ctrl}, 32'h1b, "clk_ctrl");
    acc(1'b0, SYS, 8'h0, 32'h30);
    // On-chip stopped only while status shows high-speed
    acc(1'b1, RUN, 8'h01, 32'h0);
    acc(1'b0, RUN, 8'h0, 32'h41);
    idle(2);
    chk({27'h0, clk_ctrl}, 32'h0b, "clk_ctrl");
    acc(1'b1, RUN, 8'h00, 32'h0);
    acc(1'b1, SYS, 8'h00, 32'h0);
    idle(3);
    chk({27'h0, clk_ctrl}, 32'h1a, "clk_ctrl");
    pulse(1'b0);
    acc(1'b0, STAT, 8'h0, 32'h00);
    idle(1);
    chk({30'h0, clk_ctrl.onchip_run, clk_ctrl.xtal_run}, 32'h0, "osc");
    acc(1'b1, WSEL, 8'h01, 32'h0);
    pulse(1'b1);
    xtal(511);
    idle(4);
    acc(1'b0, STAT, 8'h0, 32'h80);
    xtal(1);
    idle(4);
    acc(1'b0, STAT, 8'h0, 32'hc0);
    acc(1'b1, RUN, 8'h80, 32'h0);
    acc(1'b0, STAT, 8'h0, 32'h00);
    idle(1);
    chk({30'h0, clk_ctrl.xtal_run, clk_ctrl.ext_accept}, 32'h0, "hs");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      // Whole-byte writes only
      acc(1'b1, WSEL, {seed[7:3], i[2:0]}, 32'h0);
      acc(1'b0, WSEL, 8'h0, {29'h0, i[2:0]});
    end
    idle(3);
    print_verdict();
  end
endmodule
`default_nettype wire
